// [pfr_pkg.sv]
// shared constants and carrier types for the transmit port field router
package pfr_pkg;
   // register byte offsets
   localparam logic [7:0] PFR_OFS_CFG = 8'h00;
   localparam logic [7:0] PFR_OFS_POS = 8'h04;
   localparam logic [7:0] PFR_OFS_MOD = 8'h08;
   localparam logic [7:0] PFR_OFS_STAT = 8'h0c;
   // field positions in the configuration word
   localparam int PFR_CFG_WIDTH_LSB = 0;
   localparam int PFR_CFG_MAX_LSB = 4;
   localparam int PFR_CFG_TAG_BIT = 12;
   // field positions in the position word
   localparam int PFR_POS_BYTE_LSB = 0;
   localparam int PFR_POS_BIT_LSB = 3;
   // field positions in the modify word
   localparam int PFR_MOD_PORT_LSB = 0;
   localparam int PFR_MOD_REPL_BIT = 8;
   // field positions in the status word
   localparam int PFR_STAT_LAST_LSB = 16;
   // reset values
   localparam logic [2:0] PFR_RST_WIDTH = 3'h5;
   localparam logic [4:0] PFR_RST_MAX = 5'h1e;
   localparam logic [2:0] PFR_RST_BIT = 3'h0;
   // field and header geometry
   localparam logic [2:0] PFR_MAX_WIDTH = 3'h5;
   localparam int PFR_HDR_BYTES = 8;
   localparam logic [6:0] PFR_LIM_NOTAG = 7'h20;
   localparam logic [6:0] PFR_LIM_TAG = 7'h40;

   // one byte of the cell stream
   typedef struct packed {
      logic [7:0] data;
      logic sop;
      logic eop;
      logic cfg; // in-band configuration cell, valid with sop
   } pfr_in_t;

   typedef struct packed {
      logic [7:0] data;
      logic sop;
      logic eop;
   } pfr_out_t;
endpackage : pfr_pkg

// [pfr_field_extract.sv]
// reads the port field out of a captured header, trimmed at the header end
`timescale 1ns/1ps
module pfr_field_extract
   import pfr_pkg::*;
(
   // captured header and field geometry
   input wire logic [63:0] hdr_i,
   input wire logic [6:0] pos_i,
   input wire logic [2:0] width_i,
   input wire logic [6:0] limit_i,
   // extracted value and bits really used
   output logic [4:0] value_o,
   output logic [2:0] eff_w_o
);
   // walk msb first, stop at the header end so payload is never read
   always_comb
   begin
      logic [6:0] q;
      q = 7'h00;
      value_o = 5'h00;
      eff_w_o = 3'h0;
      for (int i = 0; i < 5; i++)
      begin
         q = pos_i + 7'(i);
         if (3'(i) < width_i && q < limit_i)
         begin
            value_o = {value_o[3:0], hdr_i[6'(7'd63 - q)]};
            eff_w_o = eff_w_o + 3'h1;
         end
      end
   end
endmodule : pfr_field_extract

// [pfr_field_insert.sv]
// writes a substitute port value over the field bits actually used
`timescale 1ns/1ps
module pfr_field_insert
   import pfr_pkg::*;
(
   // original header and field geometry
   input wire logic [63:0] hdr_i,
   input wire logic [6:0] pos_i,
   input wire logic [2:0] eff_w_i,
   input wire logic [4:0] port_i,
   // header with field replaced
   output logic [63:0] hdr_o
);
   // one mux per header bit, serial position q sits at bit 63-q
   for (genvar q = 0; q < 64; q++)
   begin : g_bit
      wire logic [6:0] off = 7'(q) - pos_i;
      wire logic in_f = (7'(q) >= pos_i) && (off < {4'h0, eff_w_i});
      wire logic [2:0] idx = eff_w_i - 3'h1 - off[2:0];
      assign hdr_o[63-q] = in_f ? port_i[idx] : hdr_i[63-q];
   end
endmodule : pfr_field_insert

// [pfr_router.sv]
// transmit cell router: port field extract, range drop, overwrite, phy select
`timescale 1ns/1ps
// Functional notes
// - port field up to five bits, inside four header bytes, eight with tag
// - field may start at any bit and span byte boundaries
// - port values zero to programmed maximum (0..31, reset 30) are valid
// - cells whose port exceeds the maximum are dropped, sent nowhere
// - with replace enabled the field is overwritten by the new port
// - in-band configuration cells never have their field overwritten
// - field start byte comes from the start-byte setting, 0..3 or 0..7
// - start byte is loaded at reset from the three low address straps
// - field is trimmed at header end; payload is never read or changed
// - msb bit location in position bits [5:3]; 0 means bit zero
// - field width programmable one to five, resets to five
// - width zero passes every cell unchanged to phy address zero
module pfr_router
   import pfr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // start-byte straps from the address pins
   input wire logic [2:0] strap_addr_i,
   // apb register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // incoming cell stream
   input wire logic in_valid_i,
   input wire pfr_in_t in_i,
   output logic in_ready_o,
   // outgoing cell stream towards the phy bus
   output logic out_valid_o,
   output pfr_out_t out_o,
   input wire logic out_ready_i,
   output logic [4:0] phy_addr_o
);
   typedef enum logic [2:0] {S_IDLE, S_COLLECT, S_DECIDE, S_HDR, S_PASS,
      S_DROP} pfr_state_t;

   pfr_state_t state_r;
   logic [2:0] width_r;
   logic [4:0] max_r;
   logic tag_r;
   logic [2:0] sbyte_r;
   logic [2:0] sbit_r;
   logic [4:0] newport_r;
   logic repl_r;
   logic [15:0] drops_r;
   logic [4:0] last_r;
   logic [2:0] strap_s1_r;
   logic [2:0] strap_s2_r;
   logic [63:0] hdr_r;
   logic [3:0] cnt_r;
   logic [3:0] idx_r;
   logic ended_r;
   logic cfgcell_r;
   logic [4:0] phy_r;
   logic [31:0] prdata_r;

   // strap synchroniser, no reset so the level is there during reset
   always_ff @(posedge clk_i)
   begin
      strap_s1_r <= strap_addr_i;
      strap_s2_r <= strap_s1_r;
   end

   // apb decode, zero wait states, unmapped offsets answer with slverr
   wire logic setup = psel && !penable;
   wire logic wr_acc = psel && penable && pwrite && !pslverr;
   wire logic hit_cfg = paddr == PFR_OFS_CFG;
   wire logic hit_pos = paddr == PFR_OFS_POS;
   wire logic hit_mod = paddr == PFR_OFS_MOD;
   wire logic hit_stat = paddr == PFR_OFS_STAT;
   wire logic mapped = hit_cfg || hit_pos || hit_mod || hit_stat;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;

   // read data words
   wire logic [31:0] rd_cfg = (32'(width_r) << PFR_CFG_WIDTH_LSB)
      | (32'(max_r) << PFR_CFG_MAX_LSB) | (32'(tag_r) << PFR_CFG_TAG_BIT);
   wire logic [31:0] rd_pos = (32'(sbyte_r) << PFR_POS_BYTE_LSB)
      | (32'(sbit_r) << PFR_POS_BIT_LSB);
   wire logic [31:0] rd_mod = (32'(newport_r) << PFR_MOD_PORT_LSB)
      | (32'(repl_r) << PFR_MOD_REPL_BIT);
   wire logic [31:0] rd_stat = {11'h000, last_r, drops_r};
   wire logic [31:0] rd_word = hit_cfg ? rd_cfg : hit_pos ? rd_pos
      : hit_mod ? rd_mod : hit_stat ? rd_stat : 32'h0000_0000;

   // read data is latched in the setup cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         prdata_r <= 32'h0000_0000;
      else if (setup)
         prdata_r <= rd_word;
   end

   // configuration registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         width_r <= PFR_RST_WIDTH;
         max_r <= PFR_RST_MAX;
         tag_r <= 1'b0;
         sbyte_r <= strap_s2_r;
         sbit_r <= PFR_RST_BIT;
         newport_r <= 5'h00;
         repl_r <= 1'b0;
      end
      else if (wr_acc)
      begin
         if (hit_cfg)
         begin
            width_r <= pwdata[PFR_CFG_WIDTH_LSB +: 3];
            max_r <= pwdata[PFR_CFG_MAX_LSB +: 5];
            tag_r <= pwdata[PFR_CFG_TAG_BIT];
         end
         if (hit_pos)
         begin
            sbyte_r <= pwdata[PFR_POS_BYTE_LSB +: 3];
            sbit_r <= pwdata[PFR_POS_BIT_LSB +: 3];
         end
         if (hit_mod)
         begin
            newport_r <= pwdata[PFR_MOD_PORT_LSB +: 5];
            repl_r <= pwdata[PFR_MOD_REPL_BIT];
         end
      end
   end

   // field geometry: serial position of msb, header end limit
   wire logic [2:0] width_eff = (width_r > PFR_MAX_WIDTH) ? PFR_MAX_WIDTH
      : width_r;
   wire logic [6:0] field_pos = {1'b0, sbyte_r, 3'h0}
      + {4'h0, 3'h7 - sbit_r};
   wire logic [6:0] hdr_lim = tag_r ? PFR_LIM_TAG : PFR_LIM_NOTAG;
   wire logic bypass = width_r == 3'h0;

   logic [4:0] fld_val;
   logic [2:0] fld_w;
   logic [63:0] hdr_new;

   pfr_field_extract u_extract (
      .hdr_i(hdr_r),
      .pos_i(field_pos),
      .width_i(width_eff),
      .limit_i(hdr_lim),
      .value_o(fld_val),
      .eff_w_o(fld_w)
   );

   pfr_field_insert u_insert (
      .hdr_i(hdr_r),
      .pos_i(field_pos),
      .eff_w_i(fld_w),
      .port_i(newport_r),
      .hdr_o(hdr_new)
   );

   // decisions taken in the decide cycle
   wire logic out_range = !bypass && (fld_val > max_r);
   wire logic do_repl = repl_r && !cfgcell_r && !bypass;

   // stream handshakes and output selection
   wire logic in_take = in_valid_i && in_ready_o;
   wire logic out_take = out_valid_o && out_ready_i;
   wire logic [7:0] hdr_byte = hdr_r[6'(7'd63 - {idx_r, 3'h0}) -: 8];
   wire logic hdr_last = idx_r == cnt_r - 4'h1;
   assign in_ready_o = (state_r == S_IDLE) || (state_r == S_COLLECT)
      || (state_r == S_DROP) || ((state_r == S_PASS) && out_ready_i);
   assign out_valid_o = (state_r == S_HDR) || ((state_r == S_PASS)
      && in_valid_i);
   assign out_o.data = (state_r == S_HDR) ? hdr_byte : in_i.data;
   assign out_o.sop = (state_r == S_HDR) && (idx_r == 4'h0);
   assign out_o.eop = (state_r == S_HDR) ? (hdr_last && ended_r) : in_i.eop;
   assign phy_addr_o = phy_r;

   // cell state machine: collect header, decide, send header, pass or drop
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_r <= S_IDLE;
      else
         unique case (state_r)
            S_IDLE:
               if (in_take && in_i.sop)
                  state_r <= in_i.eop ? S_DECIDE : S_COLLECT;
            S_COLLECT:
               if (in_take && (in_i.eop
                  || cnt_r == 4'(PFR_HDR_BYTES - 1)))
                  state_r <= S_DECIDE;
            S_DECIDE:
               if (out_range)
                  state_r <= ended_r ? S_IDLE : S_DROP;
               else
                  state_r <= S_HDR;
            S_HDR:
               if (out_take && hdr_last)
                  state_r <= ended_r ? S_IDLE : S_PASS;
            S_PASS:
               if (in_take && in_i.eop)
                  state_r <= S_IDLE;
            S_DROP:
               if (in_take && in_i.eop)
                  state_r <= S_IDLE;
         endcase
   end

   // header capture, each new byte written into its own slot from the high end down
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hdr_r <= 64'h0;
         cnt_r <= 4'h0;
         ended_r <= 1'b0;
         cfgcell_r <= 1'b0;
      end
      else if (in_take && (state_r == S_IDLE) && in_i.sop)
      begin
         hdr_r <= {in_i.data, 56'h0};
         cnt_r <= 4'h1;
         ended_r <= in_i.eop;
         cfgcell_r <= in_i.cfg;
      end
      else if (in_take && (state_r == S_COLLECT))
      begin
         hdr_r[6'(7'd63 - {cnt_r, 3'h0}) -: 8] <= in_i.data;
         cnt_r <= cnt_r + 4'h1;
         ended_r <= in_i.eop;
      end
      else if ((state_r == S_DECIDE) && do_repl)
         hdr_r <= hdr_new;
   end

   // phy address and header read index
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phy_r <= 5'h00;
         idx_r <= 4'h0;
      end
      else if (state_r == S_DECIDE)
      begin
         phy_r <= bypass ? 5'h00 : fld_val;
         idx_r <= 4'h0;
      end
      else if (out_take && (state_r == S_HDR))
         idx_r <= idx_r + 4'h1;
   end

   // status: dropped cell count and port of the last dropped cell
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drops_r <= 16'h0000;
         last_r <= 5'h00;
      end
      else if ((state_r == S_DECIDE) && out_range)
      begin
         drops_r <= drops_r + 16'h0001;
         last_r <= fld_val;
      end
   end
endmodule : pfr_router

// [pfr_router_monitor.sv]
// assertion checker watching the router ports
`timescale 1ns/1ps
module pfr_router_monitor
   import pfr_pkg::*;
(
   // clock, reset and straps
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] strap_addr_i,
   // apb port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // output stream
   input wire logic out_valid_o,
   input wire pfr_out_t out_o,
   input wire logic out_ready_i,
   input wire logic [4:0] phy_addr_o
);
   logic [2:0] w_r;
   logic [2:0] st_r;
   logic [4:0] m_r;
   logic cw_r;
   logic pw_r;
   // access decode
   wire acc = psel & penable;
   wire rd_cfg = acc & ~pwrite & (paddr == PFR_OFS_CFG);
   wire rd_pos = acc & ~pwrite & (paddr == PFR_OFS_POS);
   wire wr_cfg = acc & pwrite & (paddr == PFR_OFS_CFG);
   wire wr_pos = acc & pwrite & (paddr == PFR_OFS_POS);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // shadow of width, maximum, straps and first writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         w_r <= PFR_RST_WIDTH;
         m_r <= PFR_RST_MAX;
         st_r <= strap_addr_i;
         cw_r <= 1'b0;
         pw_r <= 1'b0;
      end
      else
      begin
         w_r <= wr_cfg ? pwdata[2:0] : w_r;
         m_r <= wr_cfg ? pwdata[8:4] : m_r;
         cw_r <= cw_r | wr_cfg;
         pw_r <= pw_r | wr_pos;
      end
   end
   AST_RST_WIDTH: assert property (rd_cfg && !cw_r
      |-> prdata[2:0] == 3'h5)
      else $error("width reset value wrong");
   AST_RST_MAX: assert property (rd_cfg && !cw_r
      |-> prdata[8:4] == 5'h1e)
      else $error("maximum port reset value wrong");
   AST_CFG_RB: assert property (rd_cfg && cw_r
      |-> prdata[2:0] == w_r)
      else $error("width readback wrong");
   AST_STRAP_POS: assert property (rd_pos && !pw_r
      |-> prdata[2:0] == st_r)
      else $error("start byte not from straps");
   AST_BIT_RST: assert property (rd_pos && !pw_r
      |-> prdata[5:3] == 3'h0)
      else $error("bit location reset value wrong");
   AST_PHY_RANGE: assert property (out_valid_o && out_o.sop
      && w_r != 3'h0 |-> phy_addr_o <= m_r)
      else $error("out of range cell forwarded");
   AST_ONE_PHY: assert property (out_valid_o && w_r == 3'h0
      |-> phy_addr_o == 5'h0)
      else $error("single phy mode address not zero");
   AST_PHY_HOLD: assert property (out_valid_o && out_ready_i
      && !out_o.eop |=> $stable(phy_addr_o))
      else $error("phy address changed inside a cell");
endmodule : pfr_router_monitor

bind pfr_router pfr_router_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .strap_addr_i(strap_addr_i), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .out_valid_o(out_valid_o), .out_o(out_o), .out_ready_i(out_ready_i),
   .phy_addr_o(phy_addr_o));

// [pfr_phy_model.sv]
// phy side model taking cells with optional back-pressure
`timescale 1ns/1ps
module pfr_phy_model
   import pfr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // slow mode and ready towards the router
   input wire logic slow_i,
   output logic ready_o
);
   logic [7:0] lfsr_r;
   logic [7:0] lfsr_nxt;
   // pseudo random stall pattern
   assign lfsr_nxt = {lfsr_r[6:0],
      lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
   always_ff @(posedge clk_i)
   begin
      lfsr_r <= rst_i ? 8'h5a : lfsr_nxt;
   end
   // always ready when prompt, stalls at random when slow
   assign ready_o = ~slow_i | lfsr_r[0];
endmodule : pfr_phy_model

// [tb_pfr_router.sv]
// self-checking bench for the transmit port field router
`timescale 1ns/1ps
module tb_pfr_router import pfr_pkg::*;;
   logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, e, slow;
   logic [2:0] strap_addr_i;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic in_valid_i, in_ready_o, out_valid_o, out_ready_i;
   pfr_in_t in_i;
   pfr_out_t out_o;
   logic [4:0] phy_addr_o;
   logic [14:0] exp_q[$];
   int err_total = 0, num_checks = 0, seed = 9283, drops = 0;
   logic [31:0] cfgt[6] = '{32'h1e5, 32'h35, 32'h1e5, 32'h1e5,
      32'h11e4, 32'h1e0};
   logic [31:0] post[6] = '{32'h2, 32'h3a, 32'h13, 32'h13, 32'h3e, 32'h2};
   logic [31:0] modt[6] = '{32'h0, 32'h0, 32'h115, 32'h115, 32'h11f, 32'h11f};

   pfr_router DUT (.clk_i(clk_i), .rst_i(rst_i), .strap_addr_i(strap_addr_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid_i(in_valid_i), .in_i(in_i), .in_ready_o(in_ready_o),
      .out_valid_o(out_valid_o), .out_o(out_o), .out_ready_i(out_ready_i),
      .phy_addr_o(phy_addr_o));
   pfr_phy_model u_phy (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
      .ready_o(out_ready_i));

   // clock
   always #5 clk_i = ~clk_i;

   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   task final_report;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   // one apb transfer, result left in r and e
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask : apb

   // sends one ten byte cell of row k and notes what must come out
   task send(input int k);
      logic [63:0] h, nh;
      logic [15:0] pl;
      logic [7:0] b;
      logic [4:0] v;
      int p, w, ew, i;
      h = {$random(seed), $random(seed)};
      pl = 16'($random(seed));
      w = cfgt[k][2:0];
      p = post[k][2:0] * 8 + 7 - post[k][5:3];
      ew = (cfgt[k][12] ? 64 : 32) - p;
      ew = (ew > w) ? w : ((ew < 0) ? 0 : ew);
      v = 5'h0;
      nh = h;
      for (i = 0; i < ew; i++)
      begin
         v = {v[3:0], h[63-p-i]};
         if (modt[k][8] && k != 3)
            nh[63-p-i] = modt[k][ew-1-i];
      end
      if (w != 0 && v > cfgt[k][8:4])
         drops++;
      else
         for (i = 0; i < 10; i++)
            exp_q.push_back({(w == 0) ? 5'h0 : v,
               (i < 8) ? nh[63-8*i-:8] : pl[15-8*(i-8)-:8], i == 0, i == 9});
      for (i = 0; i < 10; i++)
      begin
         b = (i < 8) ? h[63-8*i-:8] : pl[15-8*(i-8)-:8];
         in_valid_i <= 1'b1;
         in_i <= '{data: b, sop: i == 0, eop: i == 9, cfg: k == 3};
         do @(posedge clk_i); while (in_ready_o !== 1'b1);
      end
      in_valid_i <= 1'b0;
      for (i = 0; i < 300 && exp_q.size() > 0; i++)
         @(posedge clk_i);
      @(posedge clk_i);
   endtask : send

   // compares each accepted output byte with the oldest note
   always @(posedge clk_i)
   begin
      if (rst_i === 1'b0 && out_valid_o === 1'b1 && out_ready_i === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("extra_byte", 32'h0, 32'h1);
         else
            chk("out_byte", {17'h0, exp_q.pop_front()},
               {17'h0, phy_addr_o, out_o});
      end
   end

   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      final_report();
   end

   // main sequence
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      strap_addr_i = 3'h2;
      {psel, penable, pwrite, paddr, pwdata, in_valid_i, slow} = '0;
      in_i = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      apb(1'b0, PFR_OFS_CFG, 32'h0);
      chk("cfg_reset", 32'h1e5, r);
      apb(1'b0, PFR_OFS_POS, 32'h0);
      chk("pos_reset", 32'h2, r);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b1, PFR_OFS_CFG, cfgt[k]);
         apb(1'b1, PFR_OFS_POS, post[k]);
         apb(1'b1, PFR_OFS_MOD, modt[k]);
         apb(1'b0, PFR_OFS_CFG, 32'h0);
         chk("cfg_readback", cfgt[k], r);
         apb(1'b0, PFR_OFS_POS, 32'h0);
         chk("pos_readback", post[k], r);
         apb(1'b0, PFR_OFS_MOD, 32'h0);
         chk("mod_readback", modt[k], r);
         slow <= k[0];
         repeat (3) send(k);
      end
      apb(1'b0, PFR_OFS_STAT, 32'h0);
      chk("drop_count", drops, {16'h0, r[15:0]});
      chk("notes_left", 32'h0, exp_q.size());
      final_report();
   end
endmodule : tb_pfr_router
